// >>> rtl/brtc_defs.svh
`ifndef BRTC_DEFS_SVH
`define BRTC_DEFS_SVH
// Function
// - Clock regs 00h-07h, RAM 08h-3Fh
// - Pointer wraps from 3Fh to 00h
// - All time fields held as BCD
// - Weekday advances at midnight, in sequence
// - Seconds bit 7 halts the oscillator
// - Reset time 01/01/00 01 00:00:00, halted
// - Hours bit 6 selects 12-hour mode
// - Hours bit 5: PM flag or tens
// - START copies counters into read buffers
// - Seconds write resets the divider chain
// - Written byte lands at device acknowledge
// - Fixed-zero bits always read zero
// - Disabled square wave drives output-level bit
// - Enable bit turns square wave on
// - Clock updates on 1 Hz falling edge
// - Rate bits pick 1, 4096, 8192, 32768 Hz
// - Control resets to rate bits set only
// - Detect START and STOP on bus
// - Change data only while clock low
// - Acknowledge matching slave address 1101000
// - First write byte loads the pointer
// - Pointer increments after each data byte

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define BRTC_SEC_OFS 3'h0
`define BRTC_MIN_OFS 3'h1
`define BRTC_HR_OFS 3'h2
`define BRTC_WDAY_OFS 3'h3
`define BRTC_DATE_OFS 3'h4
`define BRTC_MON_OFS 3'h5
`define BRTC_YEAR_OFS 3'h6
`define BRTC_CTRL_OFS 6'h07
`define BRTC_RAM_BASE 6'h08
`define BRTC_ADDR_TOP 6'h3f

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define BRTC_SEC_RST 8'h80
`define BRTC_HMS_RST 8'h00
`define BRTC_DAY_RST 8'h01
`define BRTC_CTRL_RST 8'h03
`define BRTC_SEC_MASK 8'hff
`define BRTC_MIN_MASK 8'h7f
`define BRTC_HR_MASK 8'h7f
`define BRTC_WDAY_MASK 8'h07
`define BRTC_DATE_MASK 8'h3f
`define BRTC_MON_MASK 8'h1f
`define BRTC_CTRL_MASK 8'h93

// ------------------------------------------------------------
// Field positions, bus address, timing
// ------------------------------------------------------------
`define BRTC_HALT_BIT 7
`define BRTC_FMT_BIT 6
`define BRTC_PM_BIT 5
`define BRTC_OUT_BIT 7
`define BRTC_SQUARE_WAVE_ENABLE_BIT 4
`define BRTC_SLAVE_ADDR 7'h68
`define BRTC_DIV_BITS 15
`define BRTC_RATE_4K_BIT 2
`define BRTC_RATE_8K_BIT 1
`define BRTC_RAM_DEPTH 56
`endif

// >>> rtl/brtc_pkg.sv
package brtc_pkg;
  // Bus engine states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } brtc_state_type;
  // Meaning of the byte being received
  typedef enum logic [1:0]
  {
    KIND_ADDR = 2'b00,
    KIND_PTR = 2'b01,
    KIND_DATA = 2'b10
  } brtc_kind_type;
endpackage

// >>> rtl/brtc_sync3.sv
`timescale 1ns/1ps
module brtc_sync3
  import brtc_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  // Async levels in, second and third stages out
  input wire logic [W-1:0] d,
  output logic [W-1:0] mid,
  output logic [W-1:0] last
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;
  logic [W-1:0] s1_next, s2_next, s3_next;

  // Shift one stage per enabled edge
  always_comb
  begin
    s1_next = en ? d : s1_reg;
    s2_next = en ? s1_reg : s2_reg;
    s3_next = en ? s2_reg : s3_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign mid = s2_reg;
  assign last = s3_reg;
endmodule

// >>> rtl/brtc_ram.sv
`timescale 1ns/1ps
`include "brtc_defs.svh"
module brtc_ram
  import brtc_pkg::*;
#(
  parameter int DEPTH = `BRTC_RAM_DEPTH,
  parameter int AW = 6
)
(
  // Clock
  input wire logic clk,
  input wire logic en,
  // Write and read ports
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_next;

  // Out-of-range index reads zero
  always_comb
  begin
    rdata_next = (int'(addr) < DEPTH) ? mem[addr] : 8'h00;
  end

  // Registered read, synchronous write
  always_ff @(posedge clk)
  begin
    if (en)
    begin
      rdata <= rdata_next;
      if (we && int'(addr) < DEPTH)
        mem[addr] <= wdata;
    end
  end
endmodule

// >>> rtl/brtc_top.sv
`timescale 1ns/1ps
`include "brtc_defs.svh"
module brtc_top
  import brtc_pkg::*;
#(
  parameter int DIV_BITS = `BRTC_DIV_BITS
)
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Crystal oscillator clock
  input wire logic osc_clk,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Open-drain square-wave pin
  output logic square_wave_pin_out,
  output logic square_wave_pin_oe
);
  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  brtc_state_type state_reg, state_next;
  brtc_kind_type kind_reg, kind_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shf_reg, shf_next;
  logic [5:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next, oe_reg, oe_next;
  logic [7:0] tm_reg [7];
  logic [7:0] tm_next [7];
  logic [7:0] buf_reg [7];
  logic [7:0] buf_next [7];
  logic [7:0] ctrl_reg, ctrl_next, rd_byte, ram_q;
  logic divrst_tgl_reg, divrst_tgl_next;
  logic [2:0] in_mid, in_last;
  logic [1:0] flt_reg, flt_next;
  logic scl_now, sda_now, scl_rise, scl_fall;
  logic start_ev, stop_ev, tick, ram_we;
  logic ptr_inc, time_we, sec_wr, day_carry;
  logic [7:0] hr;
  logic tick_tgl_reg, tick_tgl_next;

  // ----------------------------------------------------------
  // Functions
  // ----------------------------------------------------------
  // BCD increment of the low two digits
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Last BCD date of a month
  function automatic logic [7:0] month_end(input logic [7:0] m,
                                           input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  endfunction

  // Writable bits per time register
  function automatic logic [7:0] wmask(input logic [2:0] i);
    case (i)
      `BRTC_SEC_OFS: wmask = `BRTC_SEC_MASK;
      `BRTC_MIN_OFS: wmask = `BRTC_MIN_MASK;
      `BRTC_HR_OFS: wmask = `BRTC_HR_MASK;
      `BRTC_WDAY_OFS: wmask = `BRTC_WDAY_MASK;
      `BRTC_DATE_OFS: wmask = `BRTC_DATE_MASK;
      `BRTC_MON_OFS: wmask = `BRTC_MON_MASK;
      default: wmask = 8'hff;
    endcase
  endfunction

  // ----------------------------------------------------------
  // Pin filter and tick crossing
  // ----------------------------------------------------------
  brtc_sync3 #(.W(3)) u_in_sync
  (
    .clk(ref_clk),
    .arst_n(arst_n),
    .en(clk_en),
    .d({!scl_in, !sda_in, tick_tgl_reg}),
    .mid(in_mid),
    .last(in_last)
  );

  // Pin level moves once stages two and three agree
  // Pins enter inverted, so cleared stages read as an idle bus
  always_comb
  begin
    flt_next[1] = (in_mid[2] == in_last[2]) ? !in_mid[2] : flt_reg[1];
    flt_next[0] = (in_mid[1] == in_last[1]) ? !in_mid[1] : flt_reg[0];
    scl_now = flt_next[1];
    sda_now = flt_next[0];
    scl_rise = !flt_reg[1] && scl_now;
    scl_fall = flt_reg[1] && !scl_now;
    start_ev = flt_reg[1] && scl_now && flt_reg[0] && !sda_now;
    stop_ev = flt_reg[1] && scl_now && !flt_reg[0] && sda_now;
    tick = in_mid[0] ^ in_last[0];
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      flt_reg <= 2'b11;
    else if (clk_en)
      flt_reg <= flt_next;
  end

  // ----------------------------------------------------------
  // Read data and user memory
  // ----------------------------------------------------------
  always_comb
  begin
    if (ptr_reg == `BRTC_CTRL_OFS)
      rd_byte = ctrl_reg;
    else if (ptr_reg < `BRTC_RAM_BASE)
      rd_byte = buf_reg[ptr_reg[2:0]];
    else
      rd_byte = ram_q;
  end

  brtc_ram u_ram
  (
    .clk(ref_clk),
    .en(clk_en),
    .we(ram_we),
    .addr(ptr_reg - `BRTC_RAM_BASE),
    .wdata(shf_reg),
    .rdata(ram_q)
  );

  // ----------------------------------------------------------
  // Timekeeping and bus engine
  // ----------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    bit_next = bit_reg;
    shf_next = shf_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    tm_next = tm_reg;
    buf_next = buf_reg;
    ctrl_next = ctrl_reg;
    divrst_tgl_next = divrst_tgl_reg;
    ram_we = 1'b0;
    ptr_inc = 1'b0;
    time_we = 1'b0;
    sec_wr = 1'b0;
    day_carry = 1'b0;
    hr = tm_reg[`BRTC_HR_OFS];
    // Calendar advance on each one-second tick
    if (tick && !tm_reg[`BRTC_SEC_OFS][`BRTC_HALT_BIT])
    begin
      if (tm_reg[0][6:0] != 7'h59)
        tm_next[0] = bcd_inc(tm_reg[0]);
      else if (tm_reg[1] != 8'h59)
      begin
        tm_next[0] = 8'h00;
        tm_next[1] = bcd_inc(tm_reg[1]);
      end
      else
      begin
        tm_next[0] = 8'h00;
        tm_next[1] = 8'h00;
        if (hr[`BRTC_FMT_BIT])
        begin
          if (hr[4:0] == 5'h12)
            tm_next[2] = {hr[7:5], 5'h01};
          else if (hr[4:0] == 5'h11)
          begin
            tm_next[2] = {hr[7:6], !hr[5], 5'h12};
            day_carry = hr[`BRTC_PM_BIT];
          end
          else
            tm_next[2] = bcd_inc(hr);
        end
        else if (hr[5:0] == 6'h23)
        begin
          tm_next[2] = 8'h00;
          day_carry = 1'b1;
        end
        else
          tm_next[2] = bcd_inc(hr);
      end
    end
    // Midnight carry into day, date, month, year
    if (day_carry)
    begin
      tm_next[3] = (tm_reg[3] == 8'h07) ? 8'h01 : bcd_inc(tm_reg[3]);
      if (tm_reg[4] != month_end(tm_reg[5], tm_reg[6]))
        tm_next[4] = bcd_inc(tm_reg[4]);
      else
      begin
        tm_next[4] = 8'h01;
        if (tm_reg[5] != 8'h12)
          tm_next[5] = bcd_inc(tm_reg[5]);
        else
        begin
          tm_next[5] = 8'h01;
          tm_next[6] = (tm_reg[6] == 8'h99) ? 8'h00 : bcd_inc(tm_reg[6]);
        end
      end
    end
    // Bus conditions take priority over bit handling
    if (start_ev)
    begin
      state_next = ST_RX;
      kind_next = KIND_ADDR;
      bit_next = 4'h0;
      rw_next = 1'b0;
      oe_next = 1'b0;
      buf_next = tm_reg;
    end
    else if (stop_ev)
    begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RX:
        begin
          if (scl_rise)
          begin
            shf_next = {shf_reg[6:0], sda_now};
            bit_next = bit_reg + 4'h1;
          end
          else if (scl_fall && bit_reg == 4'h8)
          begin
            state_next = ST_ACK;
            oe_next = 1'b1;
            bit_next = 4'h0;
            case (kind_reg)
              KIND_ADDR:
              begin
                if (shf_reg[7:1] == `BRTC_SLAVE_ADDR)
                  rw_next = shf_reg[0];
                else
                begin
                  state_next = ST_IDLE;
                  oe_next = 1'b0;
                end
              end
              KIND_PTR: ptr_next = shf_reg[5:0];
              default:
              begin
                ptr_inc = 1'b1;
                if (ptr_reg == `BRTC_CTRL_OFS)
                  ctrl_next = shf_reg & `BRTC_CTRL_MASK;
                else if (ptr_reg < `BRTC_RAM_BASE)
                begin
                  time_we = 1'b1;
                  tm_next[ptr_reg[2:0]] = shf_reg & wmask(ptr_reg[2:0]);
                  sec_wr = (ptr_reg[2:0] == `BRTC_SEC_OFS);
                end
                else
                  ram_we = 1'b1;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            oe_next = 1'b0;
            if (rw_reg)
            begin
              state_next = ST_TX;
              shf_next = rd_byte;
              oe_next = !rd_byte[7];
            end
            else
            begin
              state_next = ST_RX;
              kind_next = (kind_reg == KIND_ADDR) ? KIND_PTR : KIND_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall && bit_reg == 4'h7)
          begin
            state_next = ST_MACK;
            oe_next = 1'b0;
            ptr_inc = 1'b1;
          end
          else if (scl_fall)
          begin
            shf_next = {shf_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'h1;
            oe_next = !shf_reg[6];
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            shf_next = {7'h00, sda_now};
          else if (scl_fall && !shf_reg[0])
          begin
            state_next = ST_TX;
            bit_next = 4'h0;
            shf_next = rd_byte;
            oe_next = !rd_byte[7];
          end
          else if (scl_fall)
            state_next = ST_IDLE;
        end
        default: ;
      endcase
    end
    if (ptr_inc)
      ptr_next = ptr_reg + 6'h01;
    if (sec_wr)
      divrst_tgl_next = !divrst_tgl_reg;
  end

  // Registers of the bus and calendar group
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= KIND_ADDR;
      bit_reg <= 4'h0;
      shf_reg <= 8'h00;
      ptr_reg <= 6'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      tm_reg[0] <= `BRTC_SEC_RST;
      tm_reg[1] <= `BRTC_HMS_RST;
      tm_reg[2] <= `BRTC_HMS_RST;
      tm_reg[3] <= `BRTC_DAY_RST;
      tm_reg[4] <= `BRTC_DAY_RST;
      tm_reg[5] <= `BRTC_DAY_RST;
      tm_reg[6] <= `BRTC_HMS_RST;
      for (int i = 0; i < 7; i++)
        buf_reg[i] <= 8'h00;
      ctrl_reg <= `BRTC_CTRL_RST;
      divrst_tgl_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      tm_reg <= tm_next;
      buf_reg <= buf_next;
      ctrl_reg <= ctrl_next;
      divrst_tgl_reg <= divrst_tgl_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // ----------------------------------------------------------
  // Oscillator domain: divider and square wave
  // ----------------------------------------------------------
  logic [6:0] o_mid, o_last;
  logic o_en, o_halt, o_square_wave_enable, o_out, o_rst, fast;
  logic [1:0] o_rs;
  logic [DIV_BITS-1:0] cnt_reg, cnt_next;
  logic sqw_reg, sqw_next, pt_reg, pt_next, nt_reg, nt_next;

  brtc_sync3 #(.W(7)) u_osc_sync
  (
    .clk(osc_clk),
    .arst_n(arst_n),
    .en(1'b1),
    .d({clk_en, tm_reg[0][`BRTC_HALT_BIT], ctrl_reg[`BRTC_SQUARE_WAVE_ENABLE_BIT],
        ctrl_reg[`BRTC_OUT_BIT], ctrl_reg[1:0], divrst_tgl_reg}),
    .mid(o_mid),
    .last(o_last)
  );

  // Divider, tick toggle and pin level
  always_comb
  begin
    {o_en, o_halt, o_square_wave_enable, o_out, o_rs} = o_mid[6:1];
    o_rst = o_mid[0] ^ o_last[0];
    cnt_next = cnt_reg;
    tick_tgl_next = tick_tgl_reg;
    if (o_en && o_rst)
      cnt_next = '0;
    else if (o_en && !o_halt)
    begin
      cnt_next = cnt_reg + 1'b1;
      if (&cnt_reg)
        tick_tgl_next = !tick_tgl_reg;
    end
    case (o_rs)
      2'b00: sqw_next = cnt_next[DIV_BITS-1];
      2'b01: sqw_next = cnt_next[`BRTC_RATE_4K_BIT];
      2'b10: sqw_next = cnt_next[`BRTC_RATE_8K_BIT];
      default: sqw_next = 1'b0;
    endcase
    if (!o_square_wave_enable)
      sqw_next = o_out;
    fast = o_square_wave_enable && (o_rs == 2'b11);
    pt_next = (o_en && !o_halt) ? !pt_reg : pt_reg;
    nt_next = (o_en && !o_halt) ? !nt_reg : nt_reg;
  end

  always_ff @(posedge osc_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
      tick_tgl_reg <= 1'b0;
      sqw_reg <= 1'b0;
      pt_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_tgl_reg <= tick_tgl_next;
      sqw_reg <= sqw_next;
      pt_reg <= pt_next;
    end
  end

  // Falling-edge half of the full-rate output
  always_ff @(negedge osc_clk or negedge arst_n)
  begin
    if (!arst_n)
      nt_reg <= 1'b0;
    else
      nt_reg <= nt_next;
  end

  // Open drain: enable pulls the pin low
  assign square_wave_pin_out = 1'b0;
  assign square_wave_pin_oe = fast ? !(pt_reg ^ nt_reg) : !sqw_reg;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_ptr_wrap: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && ptr_inc && ptr_reg == `BRTC_ADDR_TOP) |=> ptr_reg == 6'h00)
    else $error("pointer did not wrap to zero");
  chk_halt_freeze: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && tm_reg[0][7] && !time_we) |=>
      tm_reg[0] == $past(tm_reg[0]) && tm_reg[1] == $past(tm_reg[1]))
    else $error("time moved while halted");
  chk_sec_roll: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && tick && !tm_reg[0][7] && !time_we &&
     tm_reg[0][6:0] == 7'h59) |=> tm_reg[0] == 8'h00)
    else $error("seconds did not roll over");
  chk_start_snap: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && start_ev) |=> buf_reg[0] == $past(tm_reg[0]) &&
      buf_reg[2] == $past(tm_reg[2]))
    else $error("buffer not loaded on start");
  chk_div_reset: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && sec_wr) |=> divrst_tgl_reg != $past(divrst_tgl_reg))
    else $error("seconds write left divider running");
  chk_addr_miss: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && !start_ev && !stop_ev && state_reg == ST_RX &&
     kind_reg == KIND_ADDR && scl_fall && bit_reg == 4'h8 &&
     shf_reg[7:1] != `BRTC_SLAVE_ADDR) |=> state_reg == ST_IDLE && !sda_oe)
    else $error("foreign address acknowledged");
  chk_wday_wrap: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clk_en && day_carry && !time_we && tm_reg[3] == 8'h07) |=>
      tm_reg[3] == 8'h01)
    else $error("weekday did not wrap to one");
  chk_fixed_zero: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !tm_reg[1][7] && !tm_reg[2][7] && (ctrl_reg & 8'h6c) == 8'h00)
    else $error("fixed zero bit set");
  chk_sqw_static: assert property (
    @(posedge osc_clk) disable iff (!arst_n)
    !o_square_wave_enable ##1 !fast |-> square_wave_pin_oe == !$past(o_out))
    else $error("static level wrong");
  chk_tick_edge: assert property (
    @(posedge osc_clk) disable iff (!arst_n)
    (o_en && !o_rst && !o_halt && &cnt_reg) |=>
      tick_tgl_reg != $past(tick_tgl_reg) && cnt_reg == '0)
    else $error("no tick at divider wrap");
endmodule

// >>> tb/brtc_master.sv
`timescale 1ns/1ps
module brtc_master
(
  // Clock and resolved data line
  input wire logic ref_clk,
  input wire logic sda_line,
  // Open-drain pulls, high pulls low
  output logic scl_low,
  output logic sda_low
);
  // ------------------------------------------------------------
  // Two-wire bus master
  // ------------------------------------------------------------
  // Idle bus, both lines released
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // One third of a bit slot
  task automatic hp();
    repeat (6) @(posedge ref_clk);
    #2;
  endtask
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    hp();
    scl_low = 1'b0;
    hp();
    sda_low = 1'b1;
    hp();
    scl_low = 1'b1;
    hp();
  endtask
  // Stop, leaves the bus idle
  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl_low = 1'b0;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  // One bit, data moved only while clock low
  task automatic xbit(input logic b, output logic r);
    sda_low = !b;
    hp();
    scl_low = 1'b0;
    hp();
    r = sda_line;
    scl_low = 1'b1;
    hp();
  endtask
  // Byte out, msb first, returns acknowledge
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(b[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  // Byte in, last one refused
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, b[i]);
    xbit(last, r);
  endtask
endmodule

// >>> tb/tb_bcd_rtc_with_user_ram.sv
`timescale 1ns/1ps
module tb_bcd_rtc_with_user_ram
  import brtc_pkg::*;
;
  // ------------------------------------------------------------
  // Signals, clocks, instances
  // ------------------------------------------------------------
  logic ref_clk, osc_clk, arst_n, osc_on, ack;
  logic sda_oe, pin_oe, m_scl, m_sda;
  logic clk_en, sda_o, pin_o, last_oe;
  logic [7:0] got;
  logic [7:0] bq [8];
  int n_fail, total_checks, n_edge;
  wire scl = !m_scl;
  wire sda = !(m_sda | sda_oe);
  // Pointer, written byte, expected read-back
  logic [23:0] rows [9] = '{24'h01d959, 24'h029212, 24'h03f505,
    24'h04f131, 24'h05f212, 24'h069999, 24'h07ff93, 24'h3fa5a5,
    24'h085a5a};
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end
  // System clock, 50 MHz
  always #10 ref_clk = ~ref_clk;
  // Oscillator clock, 15 ns, stopped when osc_on is low
  always
  begin
    #7.5;
    if (osc_on) osc_clk = ~osc_clk;
  end
  brtc_top #(.DIV_BITS(4)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(clk_en), .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe(sda_oe), .square_wave_pin_out(pin_o),
    .square_wave_pin_oe(pin_oe));
  brtc_master m_bus (.ref_clk(ref_clk), .sda_line(sda),
    .scl_low(m_scl), .sda_low(m_sda));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Wait n cycles, settle after the edge
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Address and pointer phase
  task automatic head(input logic [5:0] p);
    m_bus.start();
    m_bus.wr(8'hd0, ack);
    `CHK("addr ack", 1'b1, ack)
    m_bus.wr({2'b00, p}, ack);
    `CHK("ptr ack", 1'b1, ack)
  endtask
  // Write n bytes of bq from pointer p
  task automatic put(input logic [5:0] p, input int n);
    head(p);
    for (int i = 0; i < n; i++)
    begin
      m_bus.wr(bq[i], ack);
      `CHK("data ack", 1'b1, ack)
    end
    m_bus.stop();
  endtask
  // Read n bytes from pointer p against bq
  task automatic get(input logic [5:0] p, input int n);
    head(p);
    m_bus.start();
    m_bus.wr(8'hd1, ack);
    `CHK("read ack", 1'b1, ack)
    for (int i = 0; i < n; i++)
    begin
      m_bus.rd(i == n - 1, got);
      `CHK("read data", bq[i], got)
    end
    m_bus.stop();
  endtask
  // Counts and verdict
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  // Main run
  initial
  begin
    ref_clk = 1'b0;
    osc_clk = 1'b0;
    osc_on = 1'b1;
    clk_en = 1'b1;
    arst_n = 1'b0;
    n_fail = 0;
    total_checks = 0;
    wt(5);
    arst_n = 1'b1;
    wt(4);
    `CHK("pin after reset", 1'b1, pin_oe)
    `CHK("sda out", 1'b0, sda_o)
    `CHK("pin out", 1'b0, pin_o)
    bq = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
    get(6'h00, 8);
    // Masked write and read-back per row
    for (int i = 0; i < 9; i++)
    begin
      bq[0] = rows[i][15:8];
      put(rows[i][21:16], 1);
      bq[0] = rows[i][7:0];
      get(rows[i][21:16], 1);
    end
    // Pointer wrap from the top of RAM
    bq[0] = 8'ha5;
    bq[1] = 8'h80;
    put(6'h3f, 2);
    get(6'h3f, 2);
    // Foreign address ignored
    m_bus.start();
    m_bus.wr(8'ha0, ack);
    `CHK("foreign ack", 1'b0, ack)
    m_bus.stop();
    // Frozen block ignores the bus
    clk_en = 1'b0;
    m_bus.start();
    m_bus.wr(8'hd0, ack);
    m_bus.stop();
    clk_en = 1'b1;
    `CHK("frozen ack", 1'b0, ack)
    // Static pin level with wave disabled
    bq[0] = 8'h80;
    put(6'h07, 1);
    wt(10);
    `CHK("pin high", 1'b0, pin_oe)
    bq[0] = 8'h00;
    put(6'h07, 1);
    wt(10);
    `CHK("pin low", 1'b1, pin_oe)
    // Midnight rollover, end of non-leap February
    osc_on = 1'b0;
    bq = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h01, 8'h00};
    put(6'h00, 7);
    osc_on = 1'b1;
    repeat (24) @(posedge osc_clk);
    osc_on = 1'b0;
    wt(10);
    bq = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01, 8'h00};
    get(6'h00, 7);
    // 12-hour 11:59:59 PM into a leap-year 29th
    bq = '{8'h59, 8'h59, 8'h71, 8'h03, 8'h28, 8'h02, 8'h04, 8'h00};
    put(6'h00, 7);
    osc_on = 1'b1;
    repeat (24) @(posedge osc_clk);
    osc_on = 1'b0;
    wt(10);
    bq = '{8'h00, 8'h00, 8'h52, 8'h04, 8'h29, 8'h02, 8'h04, 8'h00};
    get(6'h00, 7);
    // Square wave at the 4096 Hz tap: 8 edges in 32 cycles
    bq[0] = 8'h11;
    put(6'h07, 1);
    osc_on = 1'b1;
    repeat (8) @(negedge osc_clk);
    last_oe = pin_oe;
    n_edge = 0;
    repeat (32)
    begin
      @(negedge osc_clk);
      if (pin_oe !== last_oe)
        n_edge++;
      last_oe = pin_oe;
    end
    osc_on = 1'b0;
    `CHK("wave edges", 8, n_edge)
    // Mid-run reset brings back the power-up values
    arst_n = 1'b0;
    wt(2);
    arst_n = 1'b1;
    wt(4);
    `CHK("pin after rerun", 1'b1, pin_oe)
    bq = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
    get(6'h00, 8);
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule
